// *** design/port_pin_control.sv ***
/*
  Pin control for port S (4 pins) and port M (6 pins) behind an AHB-Lite
  register slave with zero wait states.
  Assumes pin levels arrive asynchronously, and that the SPI, CAN and SCI
  enables and pin controls come from logic on ref_clk.
*/
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module port_pin_control
(
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // peripheral ownership
  input  wire logic        spiEnable,
  input  wire logic [3:0]  spiPinOwn,
  input  wire logic [3:0]  spiPinDir,
  input  wire logic [3:0]  spiPinOut,
  input  wire logic        canTxEnable,
  input  wire logic        canTxData,
  input  wire logic        canRxEnable,
  input  wire logic        sciTxEnable,
  input  wire logic        sciTxData,
  input  wire logic        sciRxEnable,
  // port M pads
  input  wire logic [5:0]  portMPinIn,
  output logic [5:0]       portMPinOut,
  output logic [5:0]       portMPinOe,
  output logic [5:0]       portMPullUp,
  output logic [5:0]       portMPullDown,
  output logic [5:0]       portMReducedDrive,
  output logic [5:0]       portMPinLevel,
  // port S pads
  input  wire logic [3:0]  portSPinIn,
  output logic [3:0]       portSPinOut,
  output logic [3:0]       portSPinOe,
  output logic [3:0]       portSPullUp,
  output logic [3:0]       portSPullDown,
  output logic [3:0]       portSPinLevel
);

  localparam int MW = port_pin_control_pkg::M_W;
  localparam int SW = port_pin_control_pkg::S_W;
  localparam int SL = port_pin_control_pkg::SPI_LO;

  logic [1:0]                  rstPipe_q;
  logic                        rstSync;
  port_pin_control_pkg::state_t st_q;
  port_pin_control_pkg::state_t st_d;
  logic [MW-1:0]               mOwn;
  logic [MW-1:0]               mOwnDir;
  logic [MW-1:0]               mOwnOut;
  logic [MW-1:0]               mDirEff;
  logic [MW-1:0]               mOutVal;
  logic [MW-1:0]               mPullAct;
  logic [SW-1:0]               sOwn;
  logic [SW-1:0]               sOwnDir;
  logic [SW-1:0]               sOwnOut;
  logic [SW-1:0]               sDirEff;
  logic [SW-1:0]               sOutVal;
  logic [SW-1:0]               sPullAct;
  logic                        addrTake;
  logic [5:0]                  addrIdx;

  // reset release through two flip-flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rstPipe_q <= 2'b00;
    else
      rstPipe_q <= {rstPipe_q[0], 1'b1};
  end
  assign rstSync = rstPipe_q[1];

  // ownership of port M and port S pins by the serial peripherals
  always_comb
  begin
    mOwn    = {(spiEnable ? spiPinOwn : 4'h0), canTxEnable, canRxEnable}; // [RULE8] [RULE15]
    mOwnDir = {spiPinDir, 1'b1, 1'b0}; // [RULE9]
    mOwnOut = {spiPinOut, canTxData, 1'b0};
    sOwn    = {2'b00, sciTxEnable, sciRxEnable};
    sOwnDir = {2'b00, 1'b1, 1'b0}; // [RULE9]
    sOwnOut = {2'b00, sciTxData, 1'b0};
  end

  // effective direction and pad controls
  always_comb
  begin
    mDirEff  = (mOwn & mOwnDir) | (~mOwn & st_q.mDir); // [RULE7] [RULE10]
    mOutVal  = (mOwn & mOwnOut) | (~mOwn & st_q.mData);
    mPullAct = st_q.mPullEn & (~mDirEff | st_q.mOd); // [RULE13]
    sDirEff  = (sOwn & sOwnDir) | (~sOwn & st_q.sDir); // [RULE9] [RULE10]
    sOutVal  = (sOwn & sOwnOut) | (~sOwn & st_q.sDir & 4'h0) | (~sOwn & 4'h0);
    sPullAct = st_q.sPullEn & (~sDirEff | st_q.sOd); // [RULE16] [RULE1]
  end

  assign addrTake = hsel & htrans[1] & hready;
  assign addrIdx  = haddr[7:2];

  // next state: bus writes, readback, synchronisers, pad registers
  always_comb
  begin
    st_d        = st_q;
    st_d.ready  = 1'b1;
    st_d.mSync1 = portMPinIn;
    st_d.mSync2 = st_q.mSync1; // [RULE11]
    st_d.sSync1 = portSPinIn;
    st_d.sSync2 = st_q.sSync1;
    // data phase of a write lands in the register
    if (st_q.wrPend)
    begin
      unique case (st_q.wrIdx)
        port_pin_control_pkg::IDX_S_DIR:        st_d.sDir     = hwdata[SW-1:0];
        port_pin_control_pkg::IDX_S_PULL_EN:    st_d.sPullEn  = hwdata[SW-1:0];
        port_pin_control_pkg::IDX_S_PULL_SEL:   st_d.sPullSel = hwdata[SW-1:0];
        port_pin_control_pkg::IDX_S_OPEN_DRAIN: st_d.sOd      = hwdata[SW-1:0];
        port_pin_control_pkg::IDX_M_DATA:       st_d.mData    = hwdata[MW-1:0];
        port_pin_control_pkg::IDX_M_DIR:        st_d.mDir     = hwdata[MW-1:0];
        port_pin_control_pkg::IDX_M_DRIVE:      st_d.mDrive   = hwdata[MW-1:0];
        port_pin_control_pkg::IDX_M_PULL_EN:    st_d.mPullEn  = hwdata[MW-1:0];
        port_pin_control_pkg::IDX_M_PULL_SEL:   st_d.mPullSel = hwdata[MW-1:0];
        port_pin_control_pkg::IDX_M_OPEN_DRAIN: st_d.mOd      = hwdata[MW-1:0];
        default:                                st_d.wrIdx    = st_q.wrIdx; // sense and unmapped: dropped [RULE6]
      endcase
    end
    st_d.wrPend = addrTake & hwrite;
    st_d.wrIdx  = addrIdx;
    // read data taken from the post-write values, so a read right after a write sees it
    if (addrTake && !hwrite)
    begin
      unique case (addrIdx)
        port_pin_control_pkg::IDX_S_DIR:        st_d.rdata = {28'h000_0000, st_d.sDir};
        port_pin_control_pkg::IDX_S_PULL_EN:    st_d.rdata = {28'h000_0000, st_d.sPullEn};
        port_pin_control_pkg::IDX_S_PULL_SEL:   st_d.rdata = {28'h000_0000, st_d.sPullSel};
        port_pin_control_pkg::IDX_S_OPEN_DRAIN: st_d.rdata = {28'h000_0000, st_d.sOd};
        port_pin_control_pkg::IDX_M_DATA:
          st_d.rdata = {26'h000_0000, (st_d.mDir & st_d.mData) | (~st_d.mDir & st_q.mSync2)}; // [RULE4]
        port_pin_control_pkg::IDX_M_SENSE:      st_d.rdata = {26'h000_0000, st_q.mSync2}; // [RULE5]
        port_pin_control_pkg::IDX_M_DIR:        st_d.rdata = {26'h000_0000, st_d.mDir};
        port_pin_control_pkg::IDX_M_DRIVE:      st_d.rdata = {26'h000_0000, st_d.mDrive};
        port_pin_control_pkg::IDX_M_PULL_EN:    st_d.rdata = {26'h000_0000, st_d.mPullEn};
        port_pin_control_pkg::IDX_M_PULL_SEL:   st_d.rdata = {26'h000_0000, st_d.mPullSel};
        port_pin_control_pkg::IDX_M_OPEN_DRAIN: st_d.rdata = {26'h000_0000, st_d.mOd};
        default:                                st_d.rdata = port_pin_control_pkg::RST_RDATA;
      endcase
    end
    // pad controls, open drain only ever pulls low
    st_d.mOe  = mDirEff & (~st_q.mOd | ~mOutVal);
    st_d.mOut = mOutVal & ~st_q.mOd;
    st_d.mPu  = mPullAct & ~st_q.mPullSel; // [RULE17] [RULE13]
    st_d.mPd  = mPullAct & st_q.mPullSel; // [RULE17]
    st_d.mRd  = st_q.mDrive & mDirEff; // [RULE12]
    st_d.sOe  = sDirEff & (~st_q.sOd | ~sOutVal); // [RULE2] [RULE3]
    st_d.sOut = sOutVal & ~st_q.sOd; // [RULE2]
    st_d.sPu  = sPullAct & ~st_q.sPullSel; // [RULE1] [RULE17]
    st_d.sPd  = sPullAct & st_q.sPullSel; // [RULE1] [RULE17]
  end

  // state register, pulls come up enabled as pull-ups
  always_ff @(posedge ref_clk or negedge rstSync)
  begin
    if (!rstSync)
    begin
      st_q          <= '0;
      st_q.sPullEn  <= port_pin_control_pkg::RST_S_PULL_EN;
      st_q.mPullEn  <= port_pin_control_pkg::RST_M_PULL_EN; // [RULE14]
      st_q.mPullSel <= port_pin_control_pkg::RST_M_ZERO; // [RULE14]
      st_q.sPullSel <= port_pin_control_pkg::RST_S_ZERO;
      st_q.mPu      <= port_pin_control_pkg::RST_M_PULL_EN; // [RULE14]
      st_q.sPu      <= port_pin_control_pkg::RST_S_PULL_EN;
      st_q.wrIdx    <= port_pin_control_pkg::RST_IDX;
      st_q.rdata    <= port_pin_control_pkg::RST_RDATA;
      st_q.ready    <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // outputs straight from the state register, hresp tied to OKAY
  assign hreadyout         = st_q.ready;
  assign hresp             = port_pin_control_pkg::HRESP_OKAY;
  assign hrdata            = st_q.rdata;
  assign portMPinOut       = st_q.mOut;
  assign portMPinOe        = st_q.mOe;
  assign portMPullUp       = st_q.mPu;
  assign portMPullDown     = st_q.mPd;
  assign portMReducedDrive = st_q.mRd;
  assign portMPinLevel     = st_q.mSync2;
  assign portSPinOut       = st_q.sOut;
  assign portSPinOe        = st_q.sOe;
  assign portSPullUp       = st_q.sPu;
  assign portSPullDown     = st_q.sPd;
  assign portSPinLevel     = st_q.sSync2;

  // checks on pad and readback behaviour
  a_od_never_high: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE2]
    $past(rstSync) |-> ((portSPinOe & portSPinOut & $past(st_q.sOd)) == 4'h0))
    else $error("open-drain port S pin drove high");

  a_od_input_idle: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE3]
    $past(rstSync) |-> ((portSPinOe & ~$past(sDirEff)) == 4'h0))
    else $error("port S input pin was driven");

  a_sense_write_ignored: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE6]
    (st_q.wrPend && st_q.wrIdx == port_pin_control_pkg::IDX_M_SENSE)
    |=> $stable({st_q.mData, st_q.mDir, st_q.mDrive, st_q.mPullEn, st_q.mPullSel, st_q.mOd}))
    else $error("write to sense register changed state");

  a_sense_readback: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE5]
    (addrTake && !hwrite && addrIdx == port_pin_control_pkg::IDX_M_SENSE)
    |=> (hrdata == {26'h000_0000, $past(st_q.mSync2)}))
    else $error("sense read did not return sampled pins");

  a_data_readback: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE4]
    (addrTake && !hwrite && !st_q.wrPend && addrIdx == port_pin_control_pkg::IDX_M_DATA)
    |=> (hrdata[5:0] == (($past(st_q.mDir) & $past(st_q.mData)) | (~$past(st_q.mDir) & $past(st_q.mSync2)))))
    else $error("data readback mux wrong");

  a_rx_forced_in: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE9]
    $past(canRxEnable) && $past(rstSync) |-> !portMPinOe[0])
    else $error("can receive pin driven");

  a_tx_forced_out: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE9]
    $past(canTxEnable && !st_q.mOd[1]) && $past(rstSync) |-> portMPinOe[1] && portMPinOut[1] == $past(canTxData))
    else $error("can transmit pin not driven");

  a_dir_revert: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE10]
    $past(!spiEnable && !canTxEnable && !canRxEnable) && $past(rstSync)
    |-> ((portMPinOe & ~$past(st_q.mDir)) == 6'h00))
    else $error("port M drove a pin its direction bit calls input");

  a_pull_pushpull_off: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE13]
    $past(rstSync) |-> (((portMPullUp | portMPullDown) & $past(mDirEff & ~st_q.mOd)) == 6'h00))
    else $error("pull active on push-pull output");

  a_pull_select: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE17]
    $past(rstSync) |-> ((portSPullDown & ~$past(st_q.sPullSel)) == 4'h0) && ((portSPullUp & portSPullDown) == 4'h0))
    else $error("pull select decode wrong");

  a_pull_reset: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE14]
    $rose(rstSync) |-> (portMPullUp == 6'h3f) && (portMPullDown == 6'h00) ##1 (portMPullUp == 6'h3f))
    else $error("port M pulls not up after reset");

  a_drive_in_ignored: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE12]
    $past(rstSync) |-> ((portMReducedDrive & ~$past(mDirEff)) == 6'h00))
    else $error("reduced drive on input pin");

  a_spi_owns_pins: assert property (@(posedge ref_clk) disable iff (!rstSync) // [RULE15]
    $past(spiEnable && spiPinOwn[0] && !st_q.mOd[SL]) && $past(rstSync) |-> portMPinOe[SL] == $past(spiPinDir[0]))
    else $error("spi pin direction not followed");

endmodule // port_pin_control

`default_nettype wire

// *** design/port_pin_control_pkg.sv ***
/*
  Constants, register indices, reset values and the state record of the
  port S / port M pin control block.
  Assumes a 32-bit AHB-Lite slave with one register per aligned word.
*/
// Overview of operation
// RULE1 - each port S pull-select bit picks pull-up or pull-down, used only while the pull is enabled and the pin is an input or open-drain output.
// RULE2 - a set port S open-drain bit lets the pin drive only low, a clear bit gives push-pull drive.
// RULE3 - the port S open-drain bit does nothing on a pin that is an input.
// RULE4 - reading port M data gives the output latch where the direction bit is 1 and the pin level elsewhere.
// RULE5 - the port M sense register always returns the sampled levels of pins 5 to 0.
// RULE6 - writes to the port M sense register are dropped and change nothing.
// RULE7 - each port M direction bit makes its pin an input at 0 and an output at 1 unless a peripheral owns it.
// RULE8 - an enabled SPI or CAN controller decides the direction of the port M pins it uses.
// RULE9 - an enabled transmit channel forces its pin to output, an enabled receive channel forces it to input.
// RULE10 - once the owning channel is off, the direction bit governs the pin again.
// RULE11 - after a direction change the data and sense readbacks may be stale for up to two bus cycles.
// RULE12 - a port M drive bit selects reduced strength at 1, and is ignored while the pin is an input.
// RULE13 - a port M pull-enable bit turns the chosen pull on, only for inputs and open-drain outputs.
// RULE14 - out of reset the port M pulls are enabled as pull-ups.
// RULE15 - port M pins 5 to 2 follow the SPI status bits while the SPI governs them.
// RULE16 - each port S pull-enable bit turns the chosen pull on, only for inputs and open-drain outputs.
// RULE17 - pull-select 0 means pull-up and 1 means pull-down on both ports.
package port_pin_control_pkg;

  localparam int M_W = 6; // port M pin count
  localparam int S_W = 4; // port S pin count
  localparam int SPI_LO = 2; // lowest port M pin the SPI may own

  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_S_DIR        = 6'h0a;
  localparam logic [5:0] IDX_S_PULL_EN    = 6'h0c;
  localparam logic [5:0] IDX_S_PULL_SEL   = 6'h0d;
  localparam logic [5:0] IDX_S_OPEN_DRAIN = 6'h0e;
  localparam logic [5:0] IDX_M_DATA       = 6'h10;
  localparam logic [5:0] IDX_M_SENSE      = 6'h11;
  localparam logic [5:0] IDX_M_DIR        = 6'h12;
  localparam logic [5:0] IDX_M_DRIVE      = 6'h13;
  localparam logic [5:0] IDX_M_PULL_EN    = 6'h14;
  localparam logic [5:0] IDX_M_PULL_SEL   = 6'h15;
  localparam logic [5:0] IDX_M_OPEN_DRAIN = 6'h16;

  // reset values
  localparam logic [M_W-1:0] RST_M_ZERO    = 6'h00;
  localparam logic [M_W-1:0] RST_M_PULL_EN = 6'h3f;
  localparam logic [S_W-1:0] RST_S_ZERO    = 4'h0;
  localparam logic [S_W-1:0] RST_S_PULL_EN = 4'hf;
  localparam logic [31:0]    RST_RDATA     = 32'h0000_0000;

  // bus encodings
  localparam logic       HRESP_OKAY = 1'b0;
  localparam logic [5:0] RST_IDX    = 6'h00;

  typedef struct packed {
    logic [S_W-1:0] sDir;
    logic [S_W-1:0] sPullEn;
    logic [S_W-1:0] sPullSel;
    logic [S_W-1:0] sOd;
    logic [M_W-1:0] mData;
    logic [M_W-1:0] mDir;
    logic [M_W-1:0] mDrive;
    logic [M_W-1:0] mPullEn;
    logic [M_W-1:0] mPullSel;
    logic [M_W-1:0] mOd;
    logic [M_W-1:0] mSync1;
    logic [M_W-1:0] mSync2;
    logic [S_W-1:0] sSync1;
    logic [S_W-1:0] sSync2;
    logic           wrPend;
    logic [5:0]     wrIdx;
    logic [31:0]    rdata;
    logic           ready;
    logic [M_W-1:0] mOut;
    logic [M_W-1:0] mOe;
    logic [M_W-1:0] mPu;
    logic [M_W-1:0] mPd;
    logic [M_W-1:0] mRd;
    logic [S_W-1:0] sOut;
    logic [S_W-1:0] sOe;
    logic [S_W-1:0] sPu;
    logic [S_W-1:0] sPd;
  } state_t;

endpackage

// *** sim/pin_world.sv ***
/*
  Pad model for one port: resolves each pin level from the block's drivers,
  an outside driver, the pull devices and optional shorts.
  Assumes the block's pad controls are high active.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_world
#(
  parameter int W = 6
)
(
  input  wire logic         clk,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] pu,
  input  wire logic [W-1:0] pd,
  input  wire logic [W-1:0] extEn,
  input  wire logic [W-1:0] extVal,
  input  wire logic [W-1:0] shorted,
  output logic      [W-1:0] level
);
  logic toggle = 1'b0;

  // a floating pin wanders, so no stale level is ever seen as valid
  always @(posedge clk)
    toggle <= ~toggle;

  // short wins, then own driver, outside driver, pull, float
  always_comb
    for (int i = 0; i < W; i++)
      level[i] = shorted[i] ? extVal[i] : oe[i] ? out[i] : extEn[i] ? extVal[i] :
                 pu[i] ? 1'b1 : pd[i] ? 1'b0 : toggle ^ i[0];
endmodule // pin_world

`default_nettype wire

// *** sim/port_pin_control_test.sv ***
/*
  Self-checking bench for the port S / port M pin control block.
  Assumes the zero-wait AHB-Lite slave and two pin_world pad models.
*/
`timescale 1ns/1ps
`default_nettype none

module port_pin_control_test;
  logic refClk, resetN, hsel, hwrite, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic        spiEnable, canTxEnable, canTxData, canRxEnable, sciTxEnable, sciTxData, sciRxEnable;
  logic [3:0]  spiPinOwn, spiPinDir, spiPinOut;
  logic [5:0]  mIn, mOut, mOe, mPu, mPd, mRd, mExt, mExtEn, mShort;
  logic [3:0]  sIn, sOut, sOe, sPu, sPd;
  logic [5:0]  mLvl;
  logic [3:0]  sLvl;
  int          n_fail = 0;
  int          compares = 0;

  port_pin_control dut (.ref_clk(refClk), .reset_n(resetN), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .spiEnable(spiEnable), .spiPinOwn(spiPinOwn), .spiPinDir(spiPinDir),
    .spiPinOut(spiPinOut), .canTxEnable(canTxEnable), .canTxData(canTxData), .canRxEnable(canRxEnable),
    .sciTxEnable(sciTxEnable), .sciTxData(sciTxData), .sciRxEnable(sciRxEnable), .portMPinIn(mIn),
    .portMPinOut(mOut), .portMPinOe(mOe), .portMPullUp(mPu), .portMPullDown(mPd),
    .portMReducedDrive(mRd), .portMPinLevel(mLvl), .portSPinIn(sIn), .portSPinOut(sOut),
    .portSPinOe(sOe), .portSPullUp(sPu), .portSPullDown(sPd), .portSPinLevel(sLvl));

  pin_world #(.W(6)) padsM (.clk(refClk), .oe(mOe), .out(mOut), .pu(mPu), .pd(mPd), .extEn(mExtEn),
    .extVal(mExt), .shorted(mShort), .level(mIn));
  pin_world #(.W(4)) padsS (.clk(refClk), .oe(sOe), .out(sOut), .pu(sPu), .pd(sPd), .extEn(4'h0),
    .extVal(4'h0), .shorted(4'h0), .level(sIn));

  // free-running bus clock
  initial
  begin
    refClk = 1'b0;
    forever #12.5 refClk = ~refClk;
  end

  task automatic print_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge refClk);
  endtask

  // one edge, then more until hready is seen high, bounded
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge refClk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_fail++;
        $display("wrong value at %0t: bus ready timeout", $time);
        print_verdict();
      end
      @(posedge refClk);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h00_0000, idx, 2'b00};
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wr ? wd : 32'h0000_0000;
    wait_rdy();
    rdat = hrdata;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0000_0000, r);
    chk(r, exp, what);
  endtask

  task automatic t_reset;
    chk(mPu, 6'h3f, "m pull up");
    chk(mPd, 6'h00, "m pull down");
    chk(mOe, 6'h00, "m oe");
    rd(port_pin_control_pkg::IDX_M_PULL_EN, 32'h0000_003f, "m pull en reg");
    rd(6'h3f, 32'h0000_0000, "unmapped");
    $display("test reset done");
  endtask

  // outputs on pins 3..0, outside drives 5..4, pin 0 shorted high
  task automatic t_readback;
    mExtEn <= 6'h30;
    mExt   <= 6'h15;
    mShort <= 6'h01;
    wr(port_pin_control_pkg::IDX_M_DATA, 32'h0000_002a);
    wr(port_pin_control_pkg::IDX_M_DIR, 32'h0000_000f);
    tick(6);
    chk(mOe, 6'h0f, "m oe dir");
    chk(mOut & mOe, 6'h0a, "m out");
    chk(mLvl, 6'h1b, "m level");
    rd(port_pin_control_pkg::IDX_M_DATA, 32'h0000_001a, "m data rd");
    rd(port_pin_control_pkg::IDX_M_SENSE, 32'h0000_001b, "m sense");
    wr(port_pin_control_pkg::IDX_M_SENSE, 32'h0000_003f);
    rd(port_pin_control_pkg::IDX_M_DATA, 32'h0000_001a, "data after sense wr");
    rd(port_pin_control_pkg::IDX_M_DIR, 32'h0000_000f, "dir after sense wr");
    mShort <= 6'h00;
    $display("test readback done");
  endtask

  task automatic t_pull_drive;
    chk(mPu, 6'h30, "pull on inputs only");
    wr(port_pin_control_pkg::IDX_M_PULL_SEL, 32'h0000_003f);
    wr(port_pin_control_pkg::IDX_M_DRIVE, 32'h0000_003f);
    tick(3);
    chk(mPd, 6'h30, "m pull down sel");
    chk(mPu, 6'h00, "m pull up off");
    chk(mRd, 6'h0f, "m reduced");
    wr(port_pin_control_pkg::IDX_M_PULL_SEL, 32'h0000_0000);
    $display("test pull_drive done");
  endtask

  task automatic t_override;
    wr(port_pin_control_pkg::IDX_M_DIR, 32'h0000_0001);
    canTxEnable <= 1'b1;
    canTxData   <= 1'b1;
    canRxEnable <= 1'b1;
    spiEnable   <= 1'b1;
    spiPinOwn   <= 4'hf;
    spiPinDir   <= 4'h5;
    spiPinOut   <= 4'h5;
    tick(3);
    chk(mOe, 6'h16, "owned oe");
    chk(mOut & mOe, 6'h16, "owned out");
    canTxEnable <= 1'b0;
    canRxEnable <= 1'b0;
    spiEnable   <= 1'b0;
    tick(3);
    chk(mOe, 6'h01, "released oe");
    $display("test override done");
  endtask

  task automatic t_port_s;
    wr(port_pin_control_pkg::IDX_S_PULL_SEL, 32'h0000_0005);
    wr(port_pin_control_pkg::IDX_S_OPEN_DRAIN, 32'h0000_000f);
    tick(3);
    chk(sPu, 4'ha, "s pull up");
    chk(sPd, 4'h5, "s pull down");
    chk(sOe, 4'h0, "od on inputs");
    rd(port_pin_control_pkg::IDX_S_PULL_SEL, 32'h0000_0005, "s sel reg");
    sciTxEnable <= 1'b1;
    sciTxData   <= 1'b1;
    wr(port_pin_control_pkg::IDX_S_DIR, 32'h0000_000f);
    wr(port_pin_control_pkg::IDX_S_OPEN_DRAIN, 32'h0000_0002);
    tick(3);
    chk(sOe, 4'hd, "od no high drive");
    chk(sPu | sPd, 4'h2, "pull only on od");
    wr(port_pin_control_pkg::IDX_S_OPEN_DRAIN, 32'h0000_0000);
    tick(3);
    chk(sOut & sOe, 4'h2, "push pull high");
    chk(sPu | sPd, 4'h0, "no pull push pull");
    sciRxEnable <= 1'b1;
    tick(4);
    chk(sOe, 4'he, "rx pin input");
    chk(sLvl, 4'h2, "s level");
    $display("test port_s done");
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    resetN = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {spiEnable, canTxEnable, canTxData, canRxEnable, sciTxEnable, sciTxData, sciRxEnable} = '0;
    {spiPinOwn, spiPinDir, spiPinOut} = '0;
    {mExt, mExtEn, mShort} = '0;
    hsize = 3'b010;
    tick(12);
    resetN <= 1'b1;
    tick(4);
    t_reset();
    t_readback();
    t_pull_drive();
    t_override();
    t_port_s();
    print_verdict();
  end
endmodule // port_pin_control_test

`default_nettype wire
